// ==== axldo_ctrl.v ====
// Control and status logic of the auxiliary low-drop regulator.
// Assumes an APB master on core_clk, the chip mode from the state
// machine on the same clock, and comparator levels from the analog side.
//
// Operation
// - Regulator is off in init and fail-safe, frozen in stop, sleep and restart, configurable only in normal.
// - Setting the enable bit in normal mode turns the regulator on.
// - A two-bit voltage select offers 5.0, 3.3, 1.8 and 1.2 V, resetting to 3.3 V.
// - After the first enable, writes to the voltage select are ignored.
// - The lock persists while supplied; only power-on reset clears it.
// - With the lock set, software can still switch the regulator on and off.
// - Shunt overcurrent limits the current and sets only the overcurrent flag.
// - The overcurrent flag may be cleared only once the condition has gone.
// - While enabled, an output undervoltage sets the undervoltage flag.
// - The base driver temperature sensor feeds the chip overtemperature protection.
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "axldo_consts.vh"

module axldo_ctrl (
   input  wire        core_clk,
   input  wire        rst_b,
   input  wire        por_b,
   input  wire [2:0]  chip_mode,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   input  wire        shunt_over_thr,
   input  wire        aux_out_uv,
   input  wire        base_drv_hot,
   output reg         aux_ldo_on,
   output reg  [1:0]  aux_ldo_voltage_select,
   output reg         aux_ldo_current_limit,
   output reg         aux_ldo_overtemp,
   output wire        irq
);

   // =============================================================
   // Input synchronisation
   wire [2:0] sync_lv;

   axldo_sync #(
      .W (3)
   ) u_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .async_in ({base_drv_hot, aux_out_uv, shunt_over_thr}),
      .sync_out (sync_lv)
   );

   wire oc_now = sync_lv[0];
   wire uv_now = sync_lv[1];
   wire ot_now = sync_lv[2];

   // =============================================================
   // Bus decode
   wire wr_acc = psel & penable & pwrite;
   wire rd_acc = psel & penable & ~pwrite;

   function hit;
      input [11:0] a;
      input [11:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   wire mapped = hit(paddr, `AXLDO_OFF_CTRL) | hit(paddr, `AXLDO_OFF_CFG)
               | hit(paddr, `AXLDO_OFF_STAT) | hit(paddr, `AXLDO_OFF_MASK)
               | hit(paddr, `AXLDO_OFF_LIVE);

   // Zero wait states; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   wire is_normal = (chip_mode == `AXLDO_MODE_NORMAL);
   wire is_off    = (chip_mode == `AXLDO_MODE_INIT) | (chip_mode == `AXLDO_MODE_FAILSAFE);

   // =============================================================
   // Enable and configuration
   // Lock lives in the power-on domain so a chip reset cannot unlock it
   reg cfg_lock;
   reg en_bit;

   wire wr_ctrl = wr_acc & hit(paddr, `AXLDO_OFF_CTRL);
   wire wr_cfg  = wr_acc & hit(paddr, `AXLDO_OFF_CFG);

   always @(posedge core_clk) begin
      if (!por_b) begin
         cfg_lock               <= 1'b0;
         aux_ldo_voltage_select <= `AXLDO_VSEL_3V3;
      end else begin
         if (wr_cfg && is_normal && !cfg_lock)
            aux_ldo_voltage_select <= pwdata[`AXLDO_CFG_VSEL_LSB+1:`AXLDO_CFG_VSEL_LSB];
         if (wr_ctrl && is_normal && pwdata[`AXLDO_CTRL_EN_BIT])
            cfg_lock <= 1'b1;
      end
   end

   always @(posedge core_clk) begin
      if (!rst_b) begin
         en_bit <= 1'b0;
      end else if (wr_ctrl && is_normal) begin
         en_bit <= pwdata[`AXLDO_CTRL_EN_BIT];
      end else if (is_off) begin
         en_bit <= 1'b0;
      end
   end

   // In stop, sleep and restart the enable is frozen, so output follows it; init and fail-safe force it off
   always @(posedge core_clk) begin
      if (!rst_b) begin
         aux_ldo_on <= 1'b0;
      end else begin
         aux_ldo_on <= en_bit & ~is_off;
      end
   end

   // =============================================================
   // Protection outputs
   always @(posedge core_clk) begin
      if (!rst_b) begin
         aux_ldo_current_limit <= 1'b0;
         aux_ldo_overtemp      <= 1'b0;
      end else begin
         aux_ldo_current_limit <= oc_now & aux_ldo_on;
         aux_ldo_overtemp      <= ot_now;
      end
   end

   // =============================================================
   // Sticky status, cleared by reading; set beats clear
   reg [`AXLDO_NUM_EVT-1:0] stat;
   reg [`AXLDO_NUM_EVT-1:0] mask;

   wire rd_stat = rd_acc & hit(paddr, `AXLDO_OFF_STAT);
   wire [`AXLDO_NUM_EVT-1:0] evt;
   assign evt[`AXLDO_ST_OC_BIT] = oc_now;
   assign evt[`AXLDO_ST_UV_BIT] = uv_now & aux_ldo_on;
   assign evt[`AXLDO_ST_OT_BIT] = ot_now;

   always @(posedge core_clk) begin
      if (!rst_b) begin
         stat <= {`AXLDO_NUM_EVT{1'b0}};
      end else if (rd_stat) begin
         // Clear only what the read reported; a bit set after the setup
         // cycle survives, and a live condition re-asserts its flag
         stat <= (stat & ~prdata[`AXLDO_NUM_EVT-1:0]) | evt;
      end else begin
         stat <= stat | evt;
      end
   end

   always @(posedge core_clk) begin
      if (!rst_b) begin
         mask <= {`AXLDO_NUM_EVT{1'b0}};
      end else if (wr_acc && hit(paddr, `AXLDO_OFF_MASK)) begin
         mask <= pwdata[`AXLDO_NUM_EVT-1:0];
      end
   end

   assign irq = |(stat & mask);

   // =============================================================
   // Read data
   reg [31:0] next_prdata;

   always @* begin
      next_prdata = `AXLDO_ZERO32;
      if (hit(paddr, `AXLDO_OFF_CTRL))
         next_prdata[`AXLDO_CTRL_EN_BIT] = en_bit;
      else if (hit(paddr, `AXLDO_OFF_CFG)) begin
         next_prdata[`AXLDO_CFG_VSEL_LSB+1:`AXLDO_CFG_VSEL_LSB] = aux_ldo_voltage_select;
         next_prdata[`AXLDO_CFG_LOCK_BIT] = cfg_lock;
      end else if (hit(paddr, `AXLDO_OFF_STAT))
         next_prdata[`AXLDO_NUM_EVT-1:0] = stat;
      else if (hit(paddr, `AXLDO_OFF_MASK))
         next_prdata[`AXLDO_NUM_EVT-1:0] = mask;
      else if (hit(paddr, `AXLDO_OFF_LIVE))
         next_prdata[`AXLDO_NUM_EVT-1:0] = evt;
   end

   // Captured in setup phase so data is valid during the access phase
   always @(posedge core_clk) begin
      if (!rst_b) begin
         prdata <= `AXLDO_ZERO32;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_prdata;
      end
   end

endmodule
`default_nettype wire

// ==== axldo_consts.vh ====
// Constants for the auxiliary regulator control block.
// Included by the control block and the bench; holds definitions only.
`ifndef AXLDO_CONSTS_VH
`define AXLDO_CONSTS_VH

// =============================================================
// Register byte offsets
`define AXLDO_OFF_CTRL      12'h000
`define AXLDO_OFF_CFG       12'h004
`define AXLDO_OFF_STAT      12'h008
`define AXLDO_OFF_MASK      12'h00C
`define AXLDO_OFF_LIVE      12'h010

// =============================================================
// Field positions
`define AXLDO_CTRL_EN_BIT   0
`define AXLDO_CFG_VSEL_LSB  0
`define AXLDO_CFG_LOCK_BIT  2
`define AXLDO_ST_OC_BIT     0
`define AXLDO_ST_UV_BIT     1
`define AXLDO_ST_OT_BIT     2
`define AXLDO_NUM_EVT       3

// =============================================================
// Voltage select codes
`define AXLDO_VSEL_5V0      2'h0
`define AXLDO_VSEL_3V3      2'h1
`define AXLDO_VSEL_1V8      2'h2
`define AXLDO_VSEL_1V2      2'h3

// =============================================================
// Chip mode codes
`define AXLDO_MODE_INIT     3'h0
`define AXLDO_MODE_NORMAL   3'h1
`define AXLDO_MODE_STOP     3'h2
`define AXLDO_MODE_SLEEP    3'h3
`define AXLDO_MODE_RESTART  3'h4
`define AXLDO_MODE_FAILSAFE 3'h5

`define AXLDO_ZERO32        32'h00000000

`endif

// ==== axldo_sync.v ====
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes inputs come from analog comparators outside core_clk.
`timescale 1ns/1ps
`default_nettype none

module axldo_sync #(
   parameter W = 4
) (
   input  wire         core_clk,
   input  wire         rst_b,
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);

   reg [W-1:0] meta;

   // =============================================================
   // First stage feeds only the second stage
   always @(posedge core_clk) begin
      if (!rst_b) begin
         meta     <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule
`default_nettype wire

// ==== axldo_load.sv ====
// Far-side model: pass transistor, shunt and load.
// Assumes the bench commands each fault condition.
`timescale 1ns/1ps
`default_nettype none
module axldo_load (
   input  wire aux_ldo_on,
   input  wire oc_cmd,
   input  wire uv_cmd,
   input  wire hot_cmd,
   output wire shunt_over_thr,
   output wire aux_out_uv,
   output wire base_drv_hot
);
   // No load current and no driver heat while the transistor is off
   assign shunt_over_thr = oc_cmd && aux_ldo_on;
   assign aux_out_uv     = uv_cmd;
   assign base_drv_hot   = hot_cmd && aux_ldo_on;
endmodule
`default_nettype wire

// ==== axldo_chk_chk.sv ====
// Port checker for the regulator control block.
// Assumes it is bound to every axldo_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
module axldo_chk (
   input wire        core_clk,
   input wire        rst_b,
   input wire        por_b,
   input wire [2:0]  chip_mode,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        shunt_over_thr,
   input wire        aux_out_uv,
   input wire        base_drv_hot,
   input wire        aux_ldo_on,
   input wire [1:0]  aux_ldo_voltage_select,
   input wire        aux_ldo_current_limit,
   input wire        aux_ldo_overtemp,
   input wire        irq
);
   // ====
   // Lock shadow: only power-on reset may clear it
   reg  lk;
   wire wr = psel && penable && pwrite && chip_mode == 3'h1;
   wire rs = psel && !penable && !pwrite && paddr == 12'h008;
   always @(posedge core_clk)
      lk <= por_b && (lk || (wr && paddr == 12'h000 && pwdata[0]));
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b || !por_b);
   a_off_mode: assert property ((chip_mode == 3'h0 || chip_mode == 3'h5)[*3] |-> !aux_ldo_on)
      else $error("on outside normal");
   a_mode_freeze: assert property ((chip_mode > 3'h1 && chip_mode < 3'h5)[*3] |-> $stable(aux_ldo_on))
      else $error("on not frozen");
   a_lock_hold: assert property (lk |=> $stable(aux_ldo_voltage_select))
      else $error("select changed");
   a_vsel_write: assert property (wr && paddr == 12'h004 && !lk |=> aux_ldo_voltage_select == $past(pwdata[1:0]))
      else $error("select not written");
   a_enable_on: assert property (wr && paddr == 12'h000 ##1 chip_mode == 3'h1 |=> aux_ldo_on == $past(pwdata[0], 2))
      else $error("on wrong");
   a_cur_limit: assert property ((shunt_over_thr && aux_ldo_on)[*5] |-> aux_ldo_current_limit)
      else $error("no limit");
   a_oc_sticky: assert property (shunt_over_thr[*5] ##0 rs |=> prdata[0])
      else $error("oc flag lost");
   a_uv_flag: assert property ((aux_out_uv && aux_ldo_on)[*5] ##0 rs |=> prdata[1])
      else $error("uv flag lost");
   a_overtemp: assert property ($stable(base_drv_hot)[*4] |-> aux_ldo_overtemp == base_drv_hot)
      else $error("overtemp wrong");
   c_lock: cover property (lk);
   c_irq: cover property (irq);
   c_oc: cover property (rs && shunt_over_thr);
endmodule
bind axldo_ctrl axldo_chk u_chk (.*);
`default_nettype wire

// ==== aux_regulator_control_tb.sv ====
// Bench for axldo_ctrl: APB tasks, fault commands to the load model.
// Assumes the design's zero-wait APB and two-edge input sync.
`timescale 1ns/1ps
`default_nettype none
`include "axldo_consts.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %0t: got %h exp %h", $time, g, e); end end
module aux_regulator_control_tb;
   reg         core_clk = 0, rst_b = 0, por_b = 0, psel = 0, penable = 0, pwrite = 0;
   reg         oc_cmd = 0, uv_cmd = 0, hot_cmd = 0, err;
   reg  [2:0]  chip_mode = 0;
   reg  [11:0] paddr = 0;
   reg  [31:0] pwdata = 0, rd_d;
   wire        pready, pslverr, aux_ldo_on, aux_ldo_current_limit, aux_ldo_overtemp, irq;
   wire        shunt_over_thr, aux_out_uv, base_drv_hot;
   wire [31:0] prdata;
   wire [1:0]  aux_ldo_voltage_select;
   int         mismatches = 0, n_tests = 0, cyc = 0;
   axldo_ctrl DUT (.*);
   axldo_load u_load (.*);
   always #4 core_clk = ~core_clk;
   // ====
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd_d = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd_d, e)
   endtask
   // Sample a little after the edge so design updates have landed
   task tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task finish_test;
      $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         mismatches++;
         finish_test();
      end
   end
   // ====
   initial begin
      tick(16);
      @(posedge core_clk);
      rst_b <= 1'b1;
      por_b <= 1'b1;
      apb(1'b1, `AXLDO_OFF_CFG, 32'h0);
      rd(`AXLDO_OFF_CFG, 32'h1);
      apb(1'b1, 12'h020, 32'hF);
      `CHK(err, 1'b1)
      $display("T1 end");
      @(posedge core_clk) chip_mode <= `AXLDO_MODE_NORMAL;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `AXLDO_OFF_CFG, i);
         tick(1);
         `CHK(aux_ldo_voltage_select, i[1:0])
      end
      apb(1'b1, `AXLDO_OFF_CFG, `AXLDO_VSEL_1V8);
      apb(1'b1, `AXLDO_OFF_CTRL, 32'h1);
      tick(2);
      `CHK(aux_ldo_on, 1'b1)
      rd(`AXLDO_OFF_CTRL, 32'h1);
      apb(1'b1, `AXLDO_OFF_CFG, `AXLDO_VSEL_5V0);
      rd(`AXLDO_OFF_CFG, 32'h6);
      $display("T2 end");
      for (int m = 0; m < 6; m++) begin
         @(posedge core_clk) chip_mode <= `AXLDO_MODE_NORMAL;
         apb(1'b1, `AXLDO_OFF_CTRL, 32'h1);
         @(posedge core_clk) chip_mode <= m[2:0];
         apb(1'b1, `AXLDO_OFF_CTRL, 32'h0);
         tick(3);
         `CHK(aux_ldo_on, m > 1 && m < 5)
      end
      @(posedge core_clk) chip_mode <= `AXLDO_MODE_NORMAL;
      $display("T3 end");
      @(posedge core_clk) rst_b <= 1'b0;
      @(posedge core_clk) rst_b <= 1'b1;
      apb(1'b1, `AXLDO_OFF_CFG, 32'h0);
      rd(`AXLDO_OFF_CFG, 32'h6);
      apb(1'b1, `AXLDO_OFF_CTRL, 32'h1);
      apb(1'b1, `AXLDO_OFF_MASK, 32'h7);
      @(posedge core_clk) oc_cmd <= 1'b1;
      tick(6);
      `CHK({aux_ldo_current_limit, irq, aux_ldo_on}, 3'h7)
      rd(`AXLDO_OFF_STAT, 32'h1);
      rd(`AXLDO_OFF_STAT, 32'h1);
      @(posedge core_clk) oc_cmd <= 1'b0;
      tick(6);
      rd(`AXLDO_OFF_STAT, 32'h1);
      rd(`AXLDO_OFF_STAT, 32'h0);
      tick(1);
      `CHK(irq, 1'b0)
      $display("T4 end");
      apb(1'b1, `AXLDO_OFF_MASK, 32'h1);
      @(posedge core_clk);
      uv_cmd <= 1'b1;
      hot_cmd <= 1'b1;
      tick(6);
      `CHK(irq, 1'b0)
      apb(1'b1, `AXLDO_OFF_MASK, 32'h2);
      tick(1);
      `CHK({aux_ldo_overtemp, irq}, 2'h3)
      rd(`AXLDO_OFF_STAT, 32'h6);
      rd(`AXLDO_OFF_LIVE, 32'h6);
      rd(`AXLDO_OFF_MASK, 32'h2);
      $display("T5 end");
      @(posedge core_clk) por_b <= 1'b0;
      @(posedge core_clk) por_b <= 1'b1;
      rd(`AXLDO_OFF_CFG, 32'h1);
      $display("T6 end");
      finish_test();
   end
endmodule
`default_nettype wire
